// ### design/wcd_defines.svh
`ifndef WCD_DEFINES_SVH
`define WCD_DEFINES_SVH

// timing
`define WCD_SYS_PERIOD_NS   10
`define WCD_LINK_PERIOD_NS  125
`define WCD_ALERT_LAT_NS    100
`define WCD_ALERT_PW_CK     6
`define WCD_ALERT_LAT_CYC   ((`WCD_ALERT_LAT_NS + `WCD_SYS_PERIOD_NS - 1) / `WCD_SYS_PERIOD_NS)
`define WCD_ALERT_PW_CYC    ((`WCD_ALERT_PW_CK * `WCD_LINK_PERIOD_NS) / `WCD_SYS_PERIOD_NS)

// field positions
`define WCD_MR5_ERR_BIT     3
`define WCD_MPR3_FLAG_BIT   7

// burst layout
`define WCD_XFER_DATA       8
`define WCD_XFER_CRC        10
`define WCD_XFER_BC4        4
`define WCD_CRC_BEAT        8
`define WCD_TREE_BITS       72
`define WCD_LANE_BITS       8

// reset values
`define WCD_RST_STATUS      1'b0

`endif

// ### design/wcd_pkg.sv
package wcd_pkg;

    typedef struct packed {
        logic rd_dbi;
        logic wr_dbi;
        logic dm;
        logic tdqs;
        logic crc;
    } wcd_mode_s;

    typedef struct packed {
        logic [7:0] dq;
        logic       dbi_n;
    } wcd_beat_s;

    typedef enum logic [1:0] {
        WCD_ST_IDLE  = 2'b00,
        WCD_ST_BURST = 2'b01,
        WCD_ST_CHECK = 2'b10
    } wcd_cap_e;

    typedef enum logic [1:0] {
        WCD_AL_IDLE  = 2'b00,
        WCD_AL_WAIT  = 2'b01,
        WCD_AL_PULSE = 2'b10
    } wcd_alert_e;

    typedef enum logic [1:0] {
        WCD_PF_NONE = 2'b00,
        WCD_PF_DM   = 2'b01,
        WCD_PF_DBI  = 2'b10,
        WCD_PF_TDQS = 2'b11
    } wcd_pin_e;

endpackage : wcd_pkg

// ### design/wcd_crc_tree.sv
module wcd_crc_tree #(
    parameter int DW = 72
) (
    input  wire logic [DW-1:0] d_in,
    output logic      [7:0]    crc_out
);
    // serial x^8+x^2+x+1 folded into one flat xor tree
    always_comb begin
        logic [7:0] c;
        logic       fb;
        c  = 8'h00;
        fb = 1'b0;
        for (int i = DW - 1; i >= 0; i--) begin
            fb = c[7] ^ d_in[i];
            c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
        end
        crc_out = c;
    end
endmodule : wcd_crc_tree

// ### design/wcd_dbi_lane.sv
module wcd_dbi_lane #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] data_in,
    input  wire logic         dbi_n_in,
    input  wire logic         en_in,
    output logic      [W-1:0] data_out
);
    // inverted on the bus when the flag is low, restored here
    assign data_out = (en_in && !dbi_n_in) ? ~data_in : data_in;
endmodule : wcd_dbi_lane

// ### design/wcd_write_check.sv
// What this block does
// - bc4 x8 check bits come from a fixed xor tree, unused transfers read as ones
// - with a2 high a bc4 burst occupies the upper nibble of every lane
// - the tree takes 72 inputs: eight data lanes plus the mask/inversion lane
// - mask/inversion lane inputs are ones while mask and inversion are both off
// - check errors use the alert line shared with parity errors
// - a check error drives alert low for a short pulse of about six clocks
// - the pulse starts a fixed latency after the mismatch is found
// - pulse width runs from driving low until the driver releases
// - a check error sets error status bit 3 of mode register 5
// - the status bit also sets the error-log flag, bit 7 of page one register 3
// - status and flag hold until a mode register write clears bit 3
// - inversion exists on x8 and x16 parts, one pin per byte lane
// - inversion keeps fewer than half the lane lines low per strobe edge
// - the shared pin serves mask, inversion or termination strobe by mode
// - write inversion never with mask; no inversion during register reads
// - read, write inversion, mask and strobe each have their own mode bit
// - termination strobe needs inversion and mask all disabled
// - write data is inverted when the lane flag is low, kept when high
// - one flag bit accompanies each byte over transfers zero to seven
module wcd_write_check
    import wcd_pkg::*;
#(
    parameter int LANES = 1
) (
    // clock, reset, enable
    input  wire logic      CLK_SYS_IN,
    input  wire logic      NRST_IN,
    input  wire logic      CE_IN,
    // link pins
    input  wire logic      DQS_IN,
    input  wire logic [7:0] DQ_IN,
    input  wire logic      DM_DBI_N_IN,
    input  wire logic      WR_START_IN,
    input  wire logic      A2_IN,
    input  wire logic      BC4_IN,
    // mode settings, register read, mode register write, parity alert
    input  wire wcd_mode_s MODE_IN,
    input  wire logic      MPR_RD_IN,
    input  wire logic      MRS_MR5_WR_IN,
    input  wire logic      MRS_MR5_BIT3_IN,
    input  wire logic      PARITY_ALERT_IN,
    // shared alert line
    output logic           ALERT_OUT,
    output logic           ALERT_OE_OUT,
    // write data towards the array
    output logic [7:0]     WR_DATA_OUT,
    output logic           WR_MASK_OUT,
    output logic           WR_VALID_OUT,
    // status
    output logic           MR5_ERR_OUT,
    output logic [7:0]     MPR3_OUT,
    output wcd_pin_e       PIN_FUNC_OUT,
    output logic           CFG_ERR_OUT
);
    `include "wcd_defines.svh"

    localparam int LAT_CYC = `WCD_ALERT_LAT_CYC;
    localparam int PW_CYC  = `WCD_ALERT_PW_CYC;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic       dqs_s1_q, dqs_s2_q, dqs_s3_q;
    logic [7:0] dq_s1_q, dq_s2_q;
    logic       dbi_s1_q, dbi_s2_q;
    logic       st_s1_q, st_s2_q, st_s3_q;
    logic       a2_s1_q, a2_s2_q;
    logic       bc4_s1_q, bc4_s2_q;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            {dqs_s1_q, dqs_s2_q, dqs_s3_q} <= 3'h0;
            {st_s1_q, st_s2_q, st_s3_q}    <= 3'h0;
            dq_s1_q                        <= 8'h00;
            dq_s2_q                        <= 8'h00;
            {dbi_s1_q, dbi_s2_q}           <= 2'h3;
            {a2_s1_q, a2_s2_q}             <= 2'h0;
            {bc4_s1_q, bc4_s2_q}           <= 2'h0;
        end else if (CE_IN) begin
            dqs_s1_q <= DQS_IN;
            dqs_s2_q <= dqs_s1_q;
            dqs_s3_q <= dqs_s2_q;
            dq_s1_q  <= DQ_IN;
            dq_s2_q  <= dq_s1_q;
            dbi_s1_q <= DM_DBI_N_IN;
            dbi_s2_q <= dbi_s1_q;
            st_s1_q  <= WR_START_IN;
            st_s2_q  <= st_s1_q;
            st_s3_q  <= st_s2_q;
            a2_s1_q  <= A2_IN;
            a2_s2_q  <= a2_s1_q;
            bc4_s1_q <= BC4_IN;
            bc4_s2_q <= bc4_s1_q;
        end
    end

    // both strobe edges carry a transfer
    logic dqs_edge;
    logic start_rise;
    assign dqs_edge   = dqs_s2_q ^ dqs_s3_q;
    assign start_rise = st_s2_q && !st_s3_q;

    ////////////////////////////////////////////////////////////////////////////////
    // pin function and configuration checks

    logic dbi_wr_act;
    logic tree_lane_used;
    // mask wins if both are set, since inversion with mask is illegal
    assign dbi_wr_act     = MODE_IN.wr_dbi && !MODE_IN.dm && (LANES > 0);
    assign tree_lane_used = MODE_IN.dm || MODE_IN.wr_dbi;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            PIN_FUNC_OUT <= WCD_PF_NONE;
            CFG_ERR_OUT  <= 1'b0;
        end else if (CE_IN) begin
            if (MODE_IN.tdqs) begin
                PIN_FUNC_OUT <= WCD_PF_TDQS;
            end else if (MODE_IN.dm) begin
                PIN_FUNC_OUT <= WCD_PF_DM;
            end else if (MODE_IN.wr_dbi || MODE_IN.rd_dbi) begin
                PIN_FUNC_OUT <= WCD_PF_DBI;
            end else begin
                PIN_FUNC_OUT <= WCD_PF_NONE;
            end
            CFG_ERR_OUT <= (MODE_IN.wr_dbi && MODE_IN.dm) ||
                           (MODE_IN.tdqs && (MODE_IN.rd_dbi || MODE_IN.wr_dbi || MODE_IN.dm)) ||
                           (MODE_IN.rd_dbi && MPR_RD_IN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // burst capture

    wcd_cap_e   cap_q;
    logic [3:0] beat_cnt_q;
    logic       a2_q, bc4_q, crc_on_q;
    wcd_beat_s  beat_q [`WCD_XFER_CRC];
    logic [3:0] last_beat;
    logic       take;

    assign last_beat = crc_on_q ? 4'(`WCD_XFER_CRC - 1) : 4'(`WCD_XFER_DATA - 1);
    assign take      = (cap_q == WCD_ST_BURST) && dqs_edge;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            cap_q      <= WCD_ST_IDLE;
            beat_cnt_q <= 4'h0;
            a2_q       <= 1'b0;
            bc4_q      <= 1'b0;
            crc_on_q   <= 1'b0;
        end else if (CE_IN) begin
            case (cap_q)
                WCD_ST_IDLE: begin
                    if (start_rise) begin
                        cap_q      <= WCD_ST_BURST;
                        beat_cnt_q <= 4'h0;
                        a2_q       <= a2_s2_q;
                        bc4_q      <= bc4_s2_q;
                        crc_on_q   <= MODE_IN.crc;
                    end
                end
                WCD_ST_BURST: begin
                    if (take) begin
                        beat_cnt_q <= beat_cnt_q + 4'h1;
                        if (beat_cnt_q == last_beat) begin
                            cap_q <= crc_on_q ? WCD_ST_CHECK : WCD_ST_IDLE;
                        end
                    end
                end
                WCD_ST_CHECK: begin
                    cap_q <= WCD_ST_IDLE;
                end
                default: begin
                    cap_q <= WCD_ST_IDLE;
                end
            endcase
        end
    end

    // beat store has no reset; it is only read after a full burst fills it
    always_ff @(posedge CLK_SYS_IN) begin
        if (CE_IN && take && (beat_cnt_q < 4'(`WCD_XFER_CRC))) begin
            beat_q[beat_cnt_q] <= '{dq: dq_s2_q, dbi_n: dbi_s2_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write data path with inversion and mask

    logic [7:0] dbi_data;
    logic       data_beat;

    wcd_dbi_lane #(
        .W (8)
    ) u_dbi (
        .data_in  (dq_s2_q),
        .dbi_n_in (dbi_s2_q),
        .en_in    (dbi_wr_act),
        .data_out (dbi_data)
    );

    assign data_beat = take && (beat_cnt_q < (bc4_q ? 4'(`WCD_XFER_BC4) : 4'(`WCD_XFER_DATA)));

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            WR_DATA_OUT  <= 8'h00;
            WR_MASK_OUT  <= 1'b0;
            WR_VALID_OUT <= 1'b0;
        end else if (CE_IN) begin
            WR_VALID_OUT <= data_beat;
            if (data_beat) begin
                WR_DATA_OUT <= dbi_data;
                WR_MASK_OUT <= MODE_IN.dm && !dbi_s2_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // check-bit tree input and compare

    logic [`WCD_TREE_BITS-1:0] tree_in;
    logic [7:0]                crc_calc;
    logic                      err_q;

    always_comb begin
        tree_in = '1;
        for (int l = 0; l < 9; l++) begin
            for (int b = 0; b < `WCD_XFER_DATA; b++) begin
                if (!bc4_q) begin
                    tree_in[l*8+b] = (l == 8) ? beat_q[b].dbi_n : beat_q[b].dq[l];
                end else if (b < `WCD_XFER_BC4) begin
                    // a2 high moves the four beats into the upper nibble
                    tree_in[l*8+b+(a2_q ? 4 : 0)] = (l == 8) ? beat_q[b].dbi_n : beat_q[b].dq[l];
                end
            end
        end
        if (!tree_lane_used) begin
            tree_in[71:64] = 8'hff;
        end
    end

    wcd_crc_tree #(
        .DW (`WCD_TREE_BITS)
    ) u_tree (
        .d_in    (tree_in),
        .crc_out (crc_calc)
    );

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            err_q <= 1'b0;
        end else if (CE_IN) begin
            err_q <= (cap_q == WCD_ST_CHECK) && (crc_calc != beat_q[`WCD_CRC_BEAT].dq);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // error status; a new error wins over a clear in the same cycle

    logic mr5_err_q, log_flag_q;
    logic clr_req;
    assign clr_req = MRS_MR5_WR_IN && !MRS_MR5_BIT3_IN;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            mr5_err_q  <= `WCD_RST_STATUS;
            log_flag_q <= `WCD_RST_STATUS;
        end else if (CE_IN) begin
            if (err_q) begin
                mr5_err_q <= 1'b1;
            end else if (clr_req) begin
                mr5_err_q <= 1'b0;
            end
            // flag clears with the status bit; waiting for the status to drop would miss the one-cycle clear
            if (clr_req && !err_q) begin
                log_flag_q <= 1'b0;
            end else if (mr5_err_q) begin
                log_flag_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            MR5_ERR_OUT <= `WCD_RST_STATUS;
            MPR3_OUT    <= 8'h00;
        end else if (CE_IN) begin
            MR5_ERR_OUT <= mr5_err_q;
            MPR3_OUT    <= 8'(log_flag_q) << `WCD_MPR3_FLAG_BIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // alert pulse; errors during a pulse are only logged, the controller
    // reads status to learn about them

    wcd_alert_e al_q;
    logic [7:0] al_cnt_q;
    logic       crc_drive_q;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            al_q        <= WCD_AL_IDLE;
            al_cnt_q    <= 8'h00;
            crc_drive_q <= 1'b0;
        end else if (CE_IN) begin
            case (al_q)
                WCD_AL_IDLE: begin
                    if (err_q) begin
                        al_q     <= WCD_AL_WAIT;
                        al_cnt_q <= 8'(LAT_CYC - 1);
                    end
                end
                WCD_AL_WAIT: begin
                    al_cnt_q <= al_cnt_q - 8'h01;
                    if (al_cnt_q == 8'h01) begin
                        al_q        <= WCD_AL_PULSE;
                        al_cnt_q    <= 8'(PW_CYC);
                        crc_drive_q <= 1'b1;
                    end
                end
                WCD_AL_PULSE: begin
                    al_cnt_q <= al_cnt_q - 8'h01;
                    if (al_cnt_q == 8'h01) begin
                        al_q        <= WCD_AL_IDLE;
                        crc_drive_q <= 1'b0;
                    end
                end
                default: begin
                    al_q        <= WCD_AL_IDLE;
                    crc_drive_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            ALERT_OUT    <= 1'b0;
            ALERT_OE_OUT <= 1'b0;
        end else if (CE_IN) begin
            ALERT_OUT    <= 1'b0;
            ALERT_OE_OUT <= crc_drive_q || PARITY_ALERT_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic [7:0] pw_len_q;
    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            pw_len_q <= 8'h00;
        end else if (CE_IN) begin
            pw_len_q <= crc_drive_q ? pw_len_q + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!NRST_IN || !CE_IN);

    sequence s_err_idle;
        err_q && (al_q == WCD_AL_IDLE);
    endsequence
    sequence s_pulse_start;
        $rose(crc_drive_q);
    endsequence

    chk_alert_latency: assert property (s_err_idle |-> ##LAT_CYC s_pulse_start)
        else $error("alert pulse did not start after the set latency");
    chk_alert_width: assert property ($fell(crc_drive_q) |-> pw_len_q == 8'(PW_CYC))
        else $error("alert pulse width wrong");
    chk_shared_alert: assert property (crc_drive_q |=> ALERT_OE_OUT && !ALERT_OUT)
        else $error("check error not on the alert line");
    chk_status_set: assert property (err_q |=> mr5_err_q ##1 log_flag_q)
        else $error("error status or log flag not set");
    chk_status_hold: assert property (mr5_err_q && !clr_req |=> mr5_err_q)
        else $error("error status dropped without a clear");
    chk_err_cause: assert property (err_q |-> $past(cap_q) == WCD_ST_CHECK)
        else $error("error reported outside a compare");
    chk_tree_ones: assert property (!tree_lane_used |-> tree_in[71:64] == 8'hff)
        else $error("mask lane not forced to ones");
    chk_bc4_pad: assert property (bc4_q |-> (a2_q ? tree_in[3:0] : tree_in[7:4]) == 4'hf)
        else $error("unused bc4 nibble not ones");
    chk_dbi_invert: assert property (data_beat && dbi_wr_act && !dbi_s2_q |=> WR_DATA_OUT == ~$past(dq_s2_q))
        else $error("inverted lane not restored");

endmodule : wcd_write_check

// ### dv/wcd_ctrl_model.sv
// far-side controller: drives write bursts on the link pins and pulls the alert line up
module wcd_ctrl_model
    import wcd_pkg::*;
(
    // alert line from the device and mode settings
    input  wire logic      alert_oe_in,
    input  wire logic      alert_in,
    input  wire wcd_mode_s mode_in,
    // link pins towards the device
    output logic           dqs_out,
    output logic [7:0]     dq_out,
    output logic           dm_dbi_n_out,
    output logic           wr_start_out,
    output logic           a2_out,
    output logic           bc4_out,
    // resolved alert wire
    output logic           alert_n_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // open-drain: released line is pulled high by the controller
    assign alert_n_out = alert_oe_in ? alert_in : 1'b1;

    initial begin
        dqs_out = 1'b0;
        dq_out = 8'h00;
        dm_dbi_n_out = 1'b1;
        wr_start_out = 1'b0;
        a2_out = 1'b0;
        bc4_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one write burst; strobe stands still between bursts
    task automatic burst(input logic bc4, input logic a2, input logic bad,
                         input logic [63:0] dq, input logic [7:0] pin);
        logic [71:0] tree;
        logic [7:0]  crc;
        int          n;
        int          k;
        tree = '1;
        for (int b = 0; b < 8; b++) begin
            k = (bc4 && a2) ? b + 4 : b;
            if (!bc4 || b < 4) begin
                for (int l = 0; l < 8; l++) tree[l*8+k] = dq[b*8+l];
                if (mode_in.dm || mode_in.wr_dbi) tree[64+k] = pin[b];
            end
        end
        crc = 8'h00;
        for (int i = 71; i >= 0; i--) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ tree[i]) ? 8'h07 : 8'h00);
        crc = crc ^ {7'h00, bad};
        n = mode_in.crc ? 10 : 8;
        // keep start low long enough for the device to see a fresh rising edge
        #40;
        a2_out = a2;
        bc4_out = bc4;
        wr_start_out = 1'b1;
        #100;
        for (int t = 0; t < n; t++) begin
            dq_out = (t >= 8) ? ((t == 8) ? crc : 8'hff) : ((bc4 && t >= 4) ? 8'hff : dq[t*8+:8]);
            dm_dbi_n_out = (t < 8 && !(bc4 && t >= 4)) ? pin[t] : 1'b1;
            #31.25;
            dqs_out = ~dqs_out;
            #31.25;
        end
        wr_start_out = 1'b0;
        dq_out = ~dq_out;
        dm_dbi_n_out = ~dm_dbi_n_out;
    endtask : burst
endmodule : wcd_ctrl_model

// ### dv/wcd_write_check_tb.sv
`include "wcd_defines.svh"
module wcd_write_check_tb
    import wcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic bc4; logic a2; wcd_mode_s mode; logic mpr; logic brst; logic bad;
        logic [7:0] base; logic err; logic chkf; wcd_pin_e func; logic cfg;
    } wcd_row_s;

    // mode order: rd_dbi wr_dbi dm tdqs crc
    localparam wcd_row_s ROWS [14] = '{
        '{0, 0, 5'b00000, 0, 0, 0, 8'h00, 0, 1, WCD_PF_NONE, 0},
        '{0, 0, 5'b00010, 0, 0, 0, 8'h00, 0, 1, WCD_PF_TDQS, 0},
        '{0, 0, 5'b01100, 0, 0, 0, 8'h00, 0, 1, WCD_PF_DM, 1},
        '{0, 0, 5'b00110, 0, 0, 0, 8'h00, 0, 0, WCD_PF_NONE, 1},
        '{0, 0, 5'b10000, 1, 0, 0, 8'h00, 0, 0, WCD_PF_NONE, 1},
        '{0, 0, 5'b00001, 0, 1, 0, 8'h3c, 0, 1, WCD_PF_NONE, 0},
        '{0, 0, 5'b00001, 0, 1, 1, 8'h5a, 1, 1, WCD_PF_NONE, 0},
        '{0, 0, 5'b01001, 0, 1, 0, 8'ha7, 0, 1, WCD_PF_DBI, 0},
        '{0, 0, 5'b00101, 0, 1, 0, 8'h96, 0, 1, WCD_PF_DM, 0},
        '{1, 0, 5'b01001, 0, 1, 0, 8'h1e, 0, 1, WCD_PF_DBI, 0},
        '{1, 1, 5'b01001, 0, 1, 0, 8'he1, 0, 1, WCD_PF_DBI, 0},
        '{1, 1, 5'b00001, 0, 1, 1, 8'h7b, 1, 1, WCD_PF_NONE, 0},
        '{0, 0, 5'b01000, 0, 1, 1, 8'hc4, 0, 1, WCD_PF_DBI, 0},
        '{0, 1, 5'b11001, 0, 1, 1, 8'hd2, 1, 1, WCD_PF_DBI, 0}
    };

    logic       clk = 1'b0;
    logic       nrst, dqs, dm_dbi_n, wr_start, a2, bc4, mpr, mrs_wr, mrs_b3, par;
    logic [7:0] dq, wr_data, mpr3;
    wcd_mode_s  mode;
    logic       alert, alert_oe, alert_n, wr_mask, wr_valid, mr5, cfg_err;
    wcd_pin_e   pin_func;
    logic [7:0] got_d[$];
    logic       got_m[$];
    int         fails, checks, cyc, low, last_pw, pulses;

    always #5 clk = ~clk;

    wcd_write_check dut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1), .DQS_IN(dqs), .DQ_IN(dq),
        .DM_DBI_N_IN(dm_dbi_n), .WR_START_IN(wr_start), .A2_IN(a2), .BC4_IN(bc4), .MODE_IN(mode),
        .MPR_RD_IN(mpr), .MRS_MR5_WR_IN(mrs_wr), .MRS_MR5_BIT3_IN(mrs_b3), .PARITY_ALERT_IN(par),
        .ALERT_OUT(alert), .ALERT_OE_OUT(alert_oe), .WR_DATA_OUT(wr_data), .WR_MASK_OUT(wr_mask),
        .WR_VALID_OUT(wr_valid), .MR5_ERR_OUT(mr5), .MPR3_OUT(mpr3), .PIN_FUNC_OUT(pin_func),
        .CFG_ERR_OUT(cfg_err));

    wcd_ctrl_model ctrl (.alert_oe_in(alert_oe), .alert_in(alert), .mode_in(mode), .dqs_out(dqs),
        .dq_out(dq), .dm_dbi_n_out(dm_dbi_n), .wr_start_out(wr_start), .a2_out(a2), .bc4_out(bc4),
        .alert_n_out(alert_n));

    ////////////////////////////////////////////////////////////////////////////////
    // monitors: written bytes, alert low time, hang guard
    always @(posedge clk) begin
        cyc++;
        if (wr_valid === 1'b1) begin
            got_d.push_back(wr_data);
            got_m.push_back(wr_mask);
        end
        // no ceiling on the low time: alerts of chained devices may overlap
        if (alert_n === 1'b0) low++;
        else if (low != 0) begin
            last_pw = low;
            pulses++;
            low = 0;
        end
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // a write with bit 3 high must not clear; only a zero clears
    task automatic clr(input logic e);
        @(negedge clk) mrs_wr = 1'b1;
        mrs_b3 = 1'b1;
        @(negedge clk) mrs_wr = 1'b0;
        repeat (3) @(negedge clk);
        check("mr5_keep", mr5, e);
        check("mpr3_flag", mpr3, {e, 7'h00});
        mrs_wr = 1'b1;
        mrs_b3 = 1'b0;
        @(negedge clk) mrs_wr = 1'b0;
        repeat (3) @(negedge clk);
        check("mr5_clr", mr5, 1'b0);
        check("mpr3_clr", mpr3, 8'h00);
    endtask : clr

    task automatic run(input wcd_row_s r);
        logic [63:0] d;
        logic [7:0]  pin;
        int          p0;
        int          lat;
        int          n;
        pin = r.base ^ 8'h5a;
        for (int b = 0; b < 8; b++) d[b*8+:8] = r.base + 8'(b * 53);
        got_d.delete();
        got_m.delete();
        p0 = pulses;
        ctrl.burst(r.bc4, r.a2, r.bad, d, pin);
        lat = 0;
        while (alert_n === 1'b1 && lat < 60) begin
            @(posedge clk);
            lat++;
        end
        repeat (100) @(negedge clk);
        n = r.bc4 ? 4 : 8;
        check("beats", 8'(got_d.size()), 8'(n));
        for (int b = 0; b < n && b < got_d.size(); b++) begin
            check("wr_data", got_d[b], (r.mode.wr_dbi && !r.mode.dm && !pin[b]) ? ~d[b*8+:8] : d[b*8+:8]);
            check("wr_mask", got_m[b], r.mode.dm & ~pin[b]);
        end
        check("alert_pulses", 8'(pulses - p0), {7'h00, r.err});
        check("mr5", mr5, r.err);
        if (r.err) begin
            check("alert_lat", lat >= `WCD_ALERT_LAT_CYC && lat <= `WCD_ALERT_LAT_CYC + 8, 8'h01);
            check("alert_pw", 8'(last_pw), 8'(`WCD_ALERT_PW_CYC));
        end
        clr(r.err);
        // a short pulse makes the controller send the same write again
        if (r.err) begin
            p0 = pulses;
            ctrl.burst(r.bc4, r.a2, 1'b0, d, pin);
            repeat (100) @(negedge clk);
            check("retry_pulses", 8'(pulses - p0), 8'h00);
            check("retry_mr5", mr5, 1'b0);
        end
    endtask : run

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int p0;
        nrst = 1'b0;
        mode = '0;
        mpr = 1'b0;
        mrs_wr = 1'b0;
        mrs_b3 = 1'b0;
        par = 1'b0;
        repeat (20) @(negedge clk);
        check("rst_mr5", mr5, 1'b0);
        check("rst_oe", alert_oe, 1'b0);
        nrst = 1'b1;
        foreach (ROWS[i]) begin
            @(negedge clk);
            mode = ROWS[i].mode;
            mpr = ROWS[i].mpr;
            repeat (3) @(negedge clk);
            check("cfg_err", cfg_err, ROWS[i].cfg);
            if (ROWS[i].chkf) check("pin_func", pin_func, ROWS[i].func);
            if (ROWS[i].brst) run(ROWS[i]);
        end
        // a second error during a running pulse adds no pulse
        mode = 5'b00001;
        p0 = pulses;
        ctrl.burst(1'b0, 1'b0, 1'b1, 64'h0123456789abcdef, 8'h00);
        ctrl.burst(1'b0, 1'b0, 1'b1, 64'hfedcba9876543210, 8'hff);
        repeat (150) @(negedge clk);
        check("b2b_pulses", 8'(pulses - p0), 8'h01);
        check("b2b_pw", 8'(last_pw), 8'(`WCD_ALERT_PW_CYC));
        clr(1'b1);
        // parity alerts share the line, long and without check status
        par = 1'b1;
        repeat (5) @(negedge clk);
        check("par_low", alert_n, 1'b0);
        check("par_mr5", mr5, 1'b0);
        repeat (45) @(negedge clk);
        par = 1'b0;
        repeat (5) @(negedge clk);
        check("par_long", last_pw > 45, 8'h01);
        // reset in the middle of a pulse drops status and driver
        ctrl.burst(1'b0, 1'b0, 1'b1, 64'h5555aaaa3333cccc, 8'h0f);
        repeat (30) @(negedge clk);
        check("pre_rst_mr5", mr5, 1'b1);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        check("mid_rst_oe", alert_oe, 1'b0);
        check("mid_rst_mpr3", mpr3, 8'h00);
        nrst = 1'b1;
        repeat (5) @(negedge clk);
        check("post_rst_mr5", mr5, 1'b0);
        conclude();
    end
endmodule : wcd_write_check_tb
